// ==== verilog/psp_host_port.sv ====
// Host serial port with check bytes, write lock and global registers
`default_nettype none
`include "psp_map.svh"
module psp_host_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    input wire logic [15:0] pin_status,
    input wire logic [15:0] conv_result,
    input wire logic [15:0] port0_state,
    input wire logic [15:0] port0_event_set,
    output logic [15:0] global_cfg,
    output logic [15:0] conv_cfg,
    output logic [15:0] port0_cfg,
    output logic [3:0] fault_mask,
    output logic writes_unlocked
);

    // One step of the check register
    function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
        logic crc_feedback_bit;
        crc_feedback_bit = b ^ c[7];
        return {c[6:2], c[1] ^ crc_feedback_bit, c[0] ^ crc_feedback_bit,
                crc_feedback_bit};
    endfunction : crc_bit

    // Check byte of a whole word, msb first
    function automatic logic [7:0] crc_word(input logic [15:0] w);
        logic [7:0] c;
        c = `PSP_CRC_PRESET;
        for (int i = 15; i >= 0; i--) begin
            c = crc_bit(c, w[i]);
        end
        return c;
    endfunction : crc_word

    // Address to slot, valid flag on top
    function automatic logic [4:0] slot_of(input logic [6:0] a);
        case (a)
            `PSP_A_EV: slot_of = {1'b1, `PSP_S_EV};
            `PSP_A_MASK: slot_of = {1'b1, `PSP_S_MASK};
            `PSP_A_CAP: slot_of = {1'b1, `PSP_S_CAP};
            `PSP_A_PINST: slot_of = {1'b1, `PSP_S_PINST};
            `PSP_A_GCMD: slot_of = {1'b1, `PSP_S_GCMD};
            `PSP_A_GCFG: slot_of = {1'b1, `PSP_S_GCFG};
            `PSP_A_CCFG: slot_of = {1'b1, `PSP_S_CCFG};
            `PSP_A_CRES: slot_of = {1'b1, `PSP_S_CRES};
            `PSP_A_PORT0_EVENTS: slot_of = {1'b1, `PSP_S_PORT0_EVENTS};
            `PSP_A_PORT0_STATE_REPORT: slot_of = {1'b1, `PSP_S_PORT0_STATE_REPORT};
            `PSP_A_P0CFG: slot_of = {1'b1, `PSP_S_P0CFG};
            default: slot_of = 5'h00;
        endcase
    endfunction : slot_of

    // ---------------- Link domain (sck) ----------------
    logic link_rst;
    logic [5:0] bit_cnt_q;
    logic [7:0] cmd_q;
    logic [7:0] chk_q;
    logic [7:0] crc_q;
    logic [15:0] data_q;
    logic [23:0] tx_q;
    logic cmd_ok_q;
    logic rd_q;
    logic out_q;
    logic drv_q;
    logic rep_tgl_q;
    psp_pkg::psp_rep_type rep_q;
    logic [7:0] chk_full;
    logic [7:0] crc_pre;
    logic [4:0] cmd_slot;
    logic cmd_wr_ok;
    logic cmd_good;
    logic [15:0] rd_word;
    logic [4:0] tx_idx;
    logic [15:0] bank_q [`PSP_NREG];

    // Frame logic is held in reset while select is high
    assign link_rst = rst | cs_n;
    assign chk_full = {chk_q[6:0], sdi};
    assign crc_pre = (bit_cnt_q == 6'h00 || bit_cnt_q == `PSP_DATA_BEG) ?
                     `PSP_CRC_PRESET : crc_q;
    assign cmd_slot = slot_of(cmd_q[7:1]);
    assign cmd_wr_ok = cmd_slot[3:0] != `PSP_S_CAP && cmd_slot[3:0] != `PSP_S_PINST &&
                       cmd_slot[3:0] != `PSP_S_CRES && cmd_slot[3:0] != `PSP_S_PORT0_STATE_REPORT;
    assign cmd_good = chk_full == crc_q && cmd_slot[4] && (cmd_q[0] || cmd_wr_ok);
    assign rd_word = cmd_slot[4] ? bank_q[cmd_slot[3:0]] : 16'h0000;
    assign tx_idx = 5'(`PSP_DATA_CHK_END - bit_cnt_q);

    // Rising-edge counter, saturates after a full write
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_q <= 6'h00;
        end else if (bit_cnt_q != `PSP_BIT_LAST) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
        end
    end

    // Shift in command, word and check bytes
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            cmd_q <= 8'h00;
            chk_q <= 8'h00;
            crc_q <= 8'h00;
            data_q <= 16'h0000;
            tx_q <= 24'h000000;
            cmd_ok_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            chk_q <= chk_full;
            if (bit_cnt_q < `PSP_CMD_END) begin
                cmd_q <= {cmd_q[6:0], sdi};
                crc_q <= crc_bit(crc_pre, sdi);
            end
            if (bit_cnt_q >= `PSP_DATA_BEG && bit_cnt_q < `PSP_DATA_END) begin
                data_q <= {data_q[14:0], sdi};
                crc_q <= crc_bit(crc_pre, sdi);
            end
            if (bit_cnt_q == `PSP_CMD_CHK_END) begin
                cmd_ok_q <= cmd_good;
                rd_q <= cmd_good && cmd_q[0];
                tx_q <= {rd_word, crc_word(rd_word)};
            end
        end
    end

    // Hand frame outcome to the register domain by toggle
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            rep_q <= '0;
            rep_tgl_q <= 1'b0;
        end else if (bit_cnt_q == `PSP_CMD_CHK_END && !cmd_good) begin
            rep_q <= '{wr: 1'b0, cmd_f: chk_full == crc_q,
                       pec_f: chk_full != crc_q, addr: cmd_q[7:1],
                       data: 16'h0000};
            rep_tgl_q <= ~rep_tgl_q;
        end else if (bit_cnt_q == `PSP_DATA_CHK_END && cmd_ok_q && !rd_q) begin
            rep_q <= '{wr: chk_full == crc_q, cmd_f: 1'b0,
                       pec_f: chk_full != crc_q, addr: cmd_q[7:1],
                       data: data_q};
            rep_tgl_q <= ~rep_tgl_q;
        end
    end

    // Output bits change on falling edges
    always_ff @(negedge sck or posedge link_rst) begin
        if (link_rst) begin
            out_q <= 1'b1;
            drv_q <= 1'b0;
        end else if (rd_q && bit_cnt_q >= `PSP_DATA_BEG && bit_cnt_q < `PSP_BIT_LAST) begin
            out_q <= tx_q[tx_idx];
            drv_q <= 1'b1;
        end else begin
            out_q <= 1'b1;
            drv_q <= 1'b0;
        end
    end

    assign sdo = out_q;
    assign sdo_oe_n = ~drv_q;

    // ---------------- Register domain (clk) ----------------
    logic [2:0] tgl_sync_q;
    logic [2:0] cs_sync_q;
    logic tgl_seen_q;
    logic cs_low_q;
    logic rep_evt;
    logic boot_q;
    logic unlocked_q;
    logic [4:0] ev_q;
    logic [3:0] mask_q;
    logic [15:0] gcmd_q;
    logic [15:0] gcfg_q;
    logic [15:0] ccfg_q;
    logic [15:0] port0_events_q;
    logic [15:0] p0cfg_q;
    logic [4:0] wr_slot;
    logic wr_ok;
    logic [4:0] ev_set;
    logic [4:0] ev_clr;
    logic [15:0] p0_clr;
    logic [15:0] live [`PSP_NREG];

    // Three-stage synchronisers for toggle and select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tgl_sync_q <= 3'h0;
            cs_sync_q <= 3'h7;
            tgl_seen_q <= 1'b0;
            cs_low_q <= 1'b0;
        end else begin
            tgl_sync_q <= {tgl_sync_q[1:0], rep_tgl_q};
            cs_sync_q <= {cs_sync_q[1:0], cs_n};
            if (rep_evt) begin
                tgl_seen_q <= tgl_sync_q[2];
            end
            if (cs_sync_q[1] == cs_sync_q[2]) begin
                cs_low_q <= ~cs_sync_q[2];
            end
        end
    end

    assign rep_evt = tgl_sync_q[1] == tgl_sync_q[2] && tgl_sync_q[2] != tgl_seen_q;
    assign wr_slot = slot_of(rep_q.addr);
    assign wr_ok = rep_evt && rep_q.wr && wr_slot[4] &&
                   (unlocked_q || wr_slot[3:0] == `PSP_S_GCMD);
    assign ev_set = {1'b0, rep_evt && rep_q.cmd_f, rep_evt && rep_q.pec_f, 2'b00};
    assign ev_clr = (wr_ok && wr_slot[3:0] == `PSP_S_EV) ? rep_q.data[4:0] : 5'h00;
    assign p0_clr = (wr_ok && wr_slot[3:0] == `PSP_S_PORT0_EVENTS) ? rep_q.data : 16'h0000;

    // Write lock follows the command register low byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gcmd_q <= `PSP_GCMD_RST;
            unlocked_q <= 1'b0;
        end else if (wr_ok && wr_slot[3:0] == `PSP_S_GCMD) begin
            gcmd_q <= rep_q.data;
            unlocked_q <= rep_q.data[7:0] == `PSP_UNLOCK_KEY;
        end
    end

    // Sticky event registers, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ev_q <= `PSP_EV_RST;
            port0_events_q <= `PSP_PORT0_EVENTS_RST;
        end else begin
            ev_q <= (ev_q & ~ev_clr) | ev_set;
            port0_events_q <= (port0_events_q & ~p0_clr) | port0_event_set;
        end
    end

    // Plain read/write registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= `PSP_MASK_RST;
            gcfg_q <= `PSP_GCFG_RST;
            ccfg_q <= `PSP_CCFG_RST;
            p0cfg_q <= `PSP_P0CFG_RST;
        end else if (wr_ok) begin
            case (wr_slot[3:0])
                `PSP_S_MASK: mask_q <= rep_q.data[3:0];
                `PSP_S_GCFG: gcfg_q <= rep_q.data;
                `PSP_S_CCFG: ccfg_q <= rep_q.data;
                `PSP_S_P0CFG: p0cfg_q <= rep_q.data;
                default: mask_q <= mask_q;
            endcase
        end
    end

    // Live register view in slot order
    assign live[`PSP_S_EV] = {11'h000, ev_q};
    assign live[`PSP_S_MASK] = {12'h000, mask_q};
    assign live[`PSP_S_CAP] = `PSP_CAP_VAL;
    assign live[`PSP_S_PINST] = pin_status;
    assign live[`PSP_S_GCMD] = gcmd_q;
    assign live[`PSP_S_GCFG] = gcfg_q;
    assign live[`PSP_S_CCFG] = ccfg_q;
    assign live[`PSP_S_CRES] = conv_result;
    assign live[`PSP_S_PORT0_EVENTS] = port0_events_q;
    assign live[`PSP_S_PORT0_STATE_REPORT] = port0_state;
    assign live[`PSP_S_P0CFG] = p0cfg_q;

    // Read bank frozen while select is low, so the link reads stable words
    generate
        for (genvar gi = 0; gi < `PSP_NREG; gi++) begin : g_bank
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    bank_q[gi] <= 16'h0000;
                end else if (!cs_low_q) begin
                    bank_q[gi] <= live[gi];
                end
            end
        end
    endgenerate

    assign global_cfg = gcfg_q;
    assign conv_cfg = ccfg_q;
    assign port0_cfg = p0cfg_q;
    assign fault_mask = mask_q;
    assign writes_unlocked = unlocked_q;

    // First cycle after reset marker for checks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_q <= 1'b0;
        end else begin
            boot_q <= 1'b1;
        end
    end

    // ---------------- Checks ----------------
    sequence s_wr_evt;
        rep_evt && rep_q.wr && !rep_q.pec_f;
    endsequence

    sequence s_key_write;
        s_wr_evt ##0 rep_q.addr == `PSP_A_GCMD && rep_q.data[7:0] == `PSP_UNLOCK_KEY;
    endsequence

    a_sdo_float_idle: assert property (@(posedge clk) disable iff (rst)
        cs_n |-> sdo_oe_n) else $error("output driven while deselected");

    a_event_reset_vals: assert property (@(posedge clk) disable iff (rst)
        !boot_q |-> ev_q == `PSP_EV_RST && mask_q == `PSP_MASK_RST)
        else $error("event or mask reset value wrong");

    a_pec_flag_set: assert property (@(posedge clk) disable iff (rst)
        rep_evt && rep_q.pec_f |=> ev_q[`PSP_EV_PEC])
        else $error("check error flag not set");

    a_cmd_flag_set: assert property (@(posedge clk) disable iff (rst)
        rep_evt && rep_q.cmd_f |=> ev_q[`PSP_EV_CMD])
        else $error("bad command flag not set");

    a_unlock_key: assert property (@(posedge clk) disable iff (rst)
        s_key_write |=> unlocked_q ##1 unlocked_q)
        else $error("unlock key not honoured");

    a_locked_hold: assert property (@(posedge clk) disable iff (rst)
        s_wr_evt ##0 !unlocked_q && rep_q.addr == `PSP_A_GCFG |=> $stable(gcfg_q))
        else $error("locked write changed register");

    a_w1c_uvlo: assert property (@(posedge clk) disable iff (rst)
        s_wr_evt ##0 unlocked_q && rep_q.addr == `PSP_A_EV && rep_q.data[4]
        |=> !ev_q[`PSP_EV_UVLO]) else $error("write one did not clear");

    a_msb_first: assert property (@(posedge sck) disable iff (link_rst)
        bit_cnt_q == `PSP_CMD_END |-> cmd_q[7] == $past(sdi, 8))
        else $error("command not taken msb first");

    a_rd_check_byte: assert property (@(posedge sck) disable iff (link_rst)
        bit_cnt_q == `PSP_CMD_CHK_END && cmd_good && cmd_q[0]
        |=> rd_q && tx_q[7:0] == crc_word(tx_q[23:8]))
        else $error("read check byte wrong");

    a_bad_cmd_idle: assert property (@(posedge sck) disable iff (link_rst)
        bit_cnt_q == `PSP_CMD_CHK_END && !cmd_good |=> !cmd_ok_q && !rd_q)
        else $error("failed command still acted on");

    a_relock_code: assert property (@(posedge clk) disable iff (rst)
        s_wr_evt ##0 rep_q.addr == `PSP_A_GCMD && rep_q.data[7:0] != `PSP_UNLOCK_KEY
        |=> !unlocked_q) else $error("locking code did not lock");

endmodule : psp_host_port
`default_nettype wire

// ==== verilog/psp_map.svh ====
// Register offsets, reset values, field positions and frame counts
`ifndef PSP_MAP_SVH
`define PSP_MAP_SVH
// Register offsets (7-bit addresses)
`define PSP_A_EV 7'h02
`define PSP_A_MASK 7'h03
`define PSP_A_CAP 7'h06
`define PSP_A_PINST 7'h07
`define PSP_A_GCMD 7'h08
`define PSP_A_GCFG 7'h09
`define PSP_A_CCFG 7'h0A
`define PSP_A_CRES 7'h0B
`define PSP_A_PORT0_EVENTS 7'h10
`define PSP_A_PORT0_STATE_REPORT 7'h12
`define PSP_A_P0CFG 7'h13
// Register slots in the read view
`define PSP_NREG 11
`define PSP_S_EV 4'h0
`define PSP_S_MASK 4'h1
`define PSP_S_CAP 4'h2
`define PSP_S_PINST 4'h3
`define PSP_S_GCMD 4'h4
`define PSP_S_GCFG 4'h5
`define PSP_S_CCFG 4'h6
`define PSP_S_CRES 4'h7
`define PSP_S_PORT0_EVENTS 4'h8
`define PSP_S_PORT0_STATE_REPORT 4'h9
`define PSP_S_P0CFG 4'hA
// Reset values
`define PSP_EV_RST 5'h10
`define PSP_MASK_RST 4'hF
`define PSP_CAP_VAL 16'h0025
`define PSP_GCMD_RST 16'h00A0
`define PSP_GCFG_RST 16'h0009
`define PSP_CCFG_RST 16'h0000
`define PSP_PORT0_EVENTS_RST 16'h0000
`define PSP_P0CFG_RST 16'h0002
// Fault event bit positions
`define PSP_EV_UVLO 4
`define PSP_EV_CMD 3
`define PSP_EV_PEC 2
// Write-protect key in the low byte of the command register
`define PSP_UNLOCK_KEY 8'h05
// Check byte preset
`define PSP_CRC_PRESET 8'h41
// Rising-edge counts within a frame
`define PSP_CMD_END 6'h08
`define PSP_CMD_CHK_END 6'h0F
`define PSP_DATA_BEG 6'h10
`define PSP_DATA_END 6'h20
`define PSP_DATA_CHK_END 6'h27
`define PSP_BIT_LAST 6'h28
`endif

// ==== verilog/psp_pkg.sv ====
// Types shared by the host serial port
`default_nettype none
package psp_pkg;
    // Frame outcome handed from the link domain to the register domain
    typedef struct packed {
        logic wr;
        logic cmd_f;
        logic pec_f;
        logic [6:0] addr;
        logic [15:0] data;
    } psp_rep_type;
endpackage : psp_pkg
`default_nettype wire

// ==== dv/psp_host_model.sv ====
// Host-side serial master model: mode-3 frames on a 12 ns link clock
`default_nettype none
module psp_host_model (
    output logic sck,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle levels: clock parked high, device deselected
    initial begin
        sck = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // One frame: shift nbits of tx msb first, collect bits after rising edge 16
    task automatic xfer(input logic [39:0] tx, input int nbits, output logic [23:0] rx,
        output int oe_bad);
        rx = 24'h000000;
        oe_bad = 0;
        cs_n = 1'b0;
        #100;
        for (int i = 0; i < nbits; i++) begin
            sck = 1'b0;
            sdi = tx[39 - i];
            #6;
            sck = 1'b1;
            if (i >= 16) begin
                rx[39 - i] = sdo;
                if (sdo_oe_n !== 1'b0) oe_bad++;
            end
            #6;
        end
        #20;
        cs_n = 1'b1;
        sdi = ~sdi; // Released line never shows the last bit
    endtask : xfer
endmodule : psp_host_model
`default_nettype wire

// ==== dv/tb_psp_host_port.sv ====
// Self-checking bench for the host serial port
`default_nettype none
`include "psp_map.svh"
`define CHECK(what, want, got) begin cmp_count++; if ((got) !== (want)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", what, want, got); end end
module tb_psp_host_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, sck, cs_n, sdi, sdo, sdo_oe_n, writes_unlocked;
    logic [15:0] pin_status, conv_result, port0_state, port0_event_set;
    logic [15:0] global_cfg, conv_cfg, port0_cfg;
    logic [3:0] fault_mask;
    int err_total = 0;
    int cmp_count = 0;
    psp_host_port dut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .pin_status(pin_status), .conv_result(conv_result),
        .port0_state(port0_state), .port0_event_set(port0_event_set),
        .global_cfg(global_cfg), .conv_cfg(conv_cfg), .port0_cfg(port0_cfg),
        .fault_mask(fault_mask), .writes_unlocked(writes_unlocked));
    psp_host_model host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
    // Register clock, 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Check byte over n bits, msb first
    function automatic logic [7:0] crc_of(input logic [15:0] v, input int n);
        logic [7:0] c;
        logic f;
        c = 8'h41;
        for (int i = n - 1; i >= 0; i--) begin
            f = v[i] ^ c[7];
            c = {c[6:2], c[1] ^ f, c[0] ^ f, f};
        end
        return c;
    endfunction : crc_of
    task automatic gap;
        repeat (10) @(posedge clk);
    endtask : gap
    // Write frame; flips corrupt the check bytes
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [7:0] cf = 8'h00,
        input logic [7:0] df = 8'h00);
        logic [7:0] cmd;
        logic [23:0] rx;
        int oe;
        cmd = {a, 1'b0};
        host.xfer({cmd, crc_of({8'h00, cmd}, 8) ^ cf, d, crc_of(d, 16) ^ df}, 40, rx, oe);
        `CHECK("write sdo enable", 24, oe)
        gap();
    endtask : wr
    // Read frame and judge word, check byte and enable
    task automatic rd(input logic [6:0] a, input logic [15:0] want);
        logic [7:0] cmd;
        logic [23:0] rx;
        int oe;
        cmd = {a, 1'b1};
        host.xfer({cmd, crc_of({8'h00, cmd}, 8), 24'h000000}, 40, rx, oe);
        `CHECK("read word", want, rx[23:8])
        `CHECK("read check byte", crc_of(want, 16), rx[7:0])
        `CHECK("read sdo enable", 0, oe)
        #1;
        `CHECK("sdo released", 1'b1, sdo_oe_n)
        gap();
    endtask : rd
    task automatic t_reset;
        `CHECK("cfg reset", 16'h0009, global_cfg)
        `CHECK("mask reset", 4'hF, fault_mask)
        `CHECK("port cfg reset", 16'h0002, port0_cfg)
        `CHECK("lock reset", 1'b0, writes_unlocked)
        rd(`PSP_A_EV, 16'h0010);
        rd(`PSP_A_MASK, 16'h000F);
        rd(`PSP_A_CAP, 16'h0025);
        rd(`PSP_A_GCMD, 16'h00A0);
    endtask : t_reset
    task automatic t_lock;
        wr(`PSP_A_GCFG, 16'h1234);
        `CHECK("locked write", 16'h0009, global_cfg)
        wr(`PSP_A_GCMD, 16'h0005);
        `CHECK("unlocked", 1'b1, writes_unlocked)
    endtask : t_lock
    task automatic t_writes;
        wr(`PSP_A_GCFG, 16'hA5C3);
        `CHECK("cfg write", 16'hA5C3, global_cfg)
        wr(`PSP_A_CCFG, 16'h3C5A);
        `CHECK("conv cfg write", 16'h3C5A, conv_cfg)
        wr(`PSP_A_P0CFG, 16'h8001);
        `CHECK("port cfg write", 16'h8001, port0_cfg)
        wr(`PSP_A_MASK, 16'h0005);
        `CHECK("mask write", 4'h5, fault_mask)
        rd(`PSP_A_PINST, 16'hC3A5);
        rd(`PSP_A_CRES, 16'h0F0E);
        rd(`PSP_A_PORT0_STATE_REPORT, 16'h8421);
    endtask : t_writes
    task automatic t_faults;
        logic [23:0] rx;
        int oe;
        wr(`PSP_A_GCFG, 16'h0000, 8'h01);
        `CHECK("bad cmd check", 16'hA5C3, global_cfg)
        rd(`PSP_A_EV, 16'h0014);
        wr(`PSP_A_EV, 16'h0000);
        rd(`PSP_A_EV, 16'h0014);
        wr(`PSP_A_EV, 16'h0004);
        rd(`PSP_A_EV, 16'h0010);
        wr(`PSP_A_GCFG, 16'h0000, 8'h00, 8'h80);
        `CHECK("bad data check", 16'hA5C3, global_cfg)
        host.xfer({8'h0B, crc_of(16'h000B, 8), 24'h000000}, 40, rx, oe);
        `CHECK("unmapped read enable", 24, oe)
        gap();
        rd(`PSP_A_EV, 16'h001C);
        wr(`PSP_A_EV, 16'h000C);
        wr(`PSP_A_CAP, 16'hFFFF);
        rd(`PSP_A_EV, 16'h0018);
        rd(`PSP_A_CAP, 16'h0025);
        wr(`PSP_A_EV, 16'h001C);
        rd(`PSP_A_EV, 16'h0000);
    endtask : t_faults
    task automatic t_port_ev;
        @(posedge clk) port0_event_set <= 16'h0041;
        @(posedge clk) port0_event_set <= 16'h0000;
        rd(`PSP_A_PORT0_EVENTS, 16'h0041);
        rd(`PSP_A_PORT0_EVENTS, 16'h0041);
        wr(`PSP_A_PORT0_EVENTS, 16'h0001);
        rd(`PSP_A_PORT0_EVENTS, 16'h0040);
    endtask : t_port_ev
    task automatic t_abort;
        logic [23:0] rx;
        int oe;
        host.xfer({8'h12, crc_of(16'h0012, 8), 16'h0000, crc_of(16'h0000, 16)}, 20, rx, oe);
        gap();
        `CHECK("aborted write", 16'hA5C3, global_cfg)
        rd(`PSP_A_EV, 16'h0000);
        wr(`PSP_A_GCFG, 16'h0000);
        `CHECK("write after abort", 16'h0000, global_cfg)
    endtask : t_abort
    task automatic t_relock;
        wr(`PSP_A_GCMD, 16'h00A0);
        `CHECK("relocked", 1'b0, writes_unlocked)
        wr(`PSP_A_GCFG, 16'h7777);
        `CHECK("write when relocked", 16'h0000, global_cfg)
    endtask : t_relock
    task automatic close_out;
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        rst = 1'b1;
        pin_status = 16'hC3A5;
        conv_result = 16'h0F0E;
        port0_state = 16'h8421;
        port0_event_set = 16'h0000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_lock();
        t_writes();
        t_faults();
        t_port_ev();
        t_abort();
        t_relock();
        close_out();
    end
    // Watchdog, far beyond the expected span of about 42 us
    initial begin
        #500000;
        err_total++;
        close_out();
    end
endmodule : tb_psp_host_port
`default_nettype wire
